// file: dv/double_speed_clock_select_asserts.sv
// Checker for mode switching and register read timing.
`default_nettype none
module double_speed_clock_select_asserts (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] addr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       cpu_cycle,
  input wire logic [6:0] periph_cycle,
  input wire logic [6:0] periph_double,
  input wire logic       cpu_double,
  input wire logic       divided_clock
);
  // Mode levels may only move just after a divided rise, so no short clock phase appears.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (!$past(rd) || $past(addr) != 8'h8f |-> rdata == 8'h00)
    else $error("rdata not zero outside a read");
  a_cpu_mode_edge: assert property ($changed(cpu_double) |-> divided_clock)
    else $error("cpu mode moved off the divided rise");
  a_periph_mode_edge: assert property ($changed(periph_double) |-> divided_clock)
    else $error("peripheral mode moved off the divided rise");
  a_periph_needs_cpu: assert property (periph_double != 7'h00 |-> cpu_double)
    else $error("peripheral doubled while core standard");
  a_cpu_cycle_gap: assert property (cpu_cycle |=> !cpu_cycle [*8])
    else $error("machine cycles too close");
  a_periph_cycle_gap: assert property (periph_cycle[0] |=> !periph_cycle[0] [*8])
    else $error("peripheral cycles too close");
  a_divided_steady: assert property ($changed(divided_clock) |=> $stable(divided_clock) [*2])
    else $error("divided clock toggles too fast");
  a_cpu_mode_hold: assert property (!divided_clock |-> $stable(cpu_double))
    else $error("cpu mode moved while divided clock low");
endmodule
bind double_speed_clock_select double_speed_clock_select_asserts chk (
  .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .rd(rd), .rdata(rdata),
  .cpu_cycle(cpu_cycle), .periph_cycle(periph_cycle), .periph_double(periph_double),
  .cpu_double(cpu_double), .divided_clock(divided_clock));
`default_nettype wire

// file: dv/double_speed_clock_select_tb.sv
// Testbench for the double speed clock selection block.
`default_nettype none
`include "clock_select_params.svh"
module double_speed_clock_select_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0, nrst = 1'b0, xtal = 1'b0, fuse = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] xc = 3'h0;
  logic       cpu_cycle, cpu_double, divided_clock;
  logic [6:0] periph_cycle, periph_double;
  int         n_mismatch = 0, num_checks = 0;
  `define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %0h seen %0h", n, e, a); end end
  always #12.5 ref_clk = ~ref_clk;
  // Crystal at one eighth of ref_clk, so each crystal period is exactly 8 cycles.
  always @(posedge ref_clk) begin
    xc <= xc + 3'h1;
    xtal <= xc[2];
  end
  double_speed_clock_select uut (.ref_clk(ref_clk), .nrst(nrst), .crystal_input(xtal),
    .boot_double_speed_fuse(fuse), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cpu_cycle(cpu_cycle), .periph_cycle(periph_cycle),
    .periph_double(periph_double), .cpu_double(cpu_double), .divided_clock(divided_clock));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge ref_clk) wr <= 1'b0;
    repeat (40) @(posedge ref_clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk) {addr, rd} <= {a, 1'b1};
    @(posedge ref_clk) rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask
  // Counts edges between two pulses; the first pulse found only aligns the count.
  task automatic gap(input int s, input int e);
    int c;
    repeat (2) begin
      c = 0;
      do begin
        @(posedge ref_clk);
        #1 c++;
        if (c > 400) begin
          n_mismatch++;
          give_verdict();
        end
      end while ((s == 7 ? cpu_cycle : periph_cycle[s]) !== 1'b1);
    end
    `CHK("cycle gap", e, c)
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    rd_reg(`CLOCK_MODE_SELECT_ADDR, `CLOCK_MODE_SELECT_RESET);
    gap(7, `STANDARD_PERIODS * 8);
    wr_reg(`CLOCK_MODE_SELECT_ADDR, 8'ha5);
    rd_reg(`CLOCK_MODE_SELECT_ADDR, 8'ha5);
    rd_reg(8'h8e, 8'h00);
    wr_reg(`CLOCK_MODE_SELECT_ADDR, 8'h01);
    `CHK("cpu_double", 1'b1, cpu_double)
    `CHK("periph_double", 7'h7f, periph_double)
    gap(7, `DOUBLE_PERIODS * 8);
    gap(0, `DOUBLE_PERIODS * 8);
    wr_reg(`CLOCK_MODE_SELECT_ADDR, 8'hff);
    `CHK("periph_double", 7'h00, periph_double)
    gap(6, `STANDARD_PERIODS * 8);
    wr_reg(`CLOCK_MODE_SELECT_ADDR, 8'hfe);
    `CHK("cpu_double", 1'b0, cpu_double)
    gap(3, `STANDARD_PERIODS * 8);
    // A second reset with the fuse set must come up fast without any write.
    @(posedge ref_clk);
    fuse <= 1'b1;
    nrst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (40) @(posedge ref_clk);
    rd_reg(`CLOCK_MODE_SELECT_ADDR, 8'h01);
    `CHK("cpu_double", 1'b1, cpu_double)
    give_verdict();
  end
endmodule
`default_nettype wire

// file: logic/clock_select_params.svh
// Constants for the double speed clock selection block.
// Overview of operation
// - standard speed divides crystal by two
// - double speed bit picks 12 or 6
// - reset into standard speed unless fuse
// - double speed bit switches CPU clock and peripherals with bit clear
// - peripheral doubles only while its bit clear
// - mode change taken on divided rising edge
// - double speed bypasses the divide stage
// - doubled peripheral sees halved time reference
// - boot fuse may start in double speed
// - peripheral bits ignored while double speed clear
// - cleared bit 6 periods, set 12
`ifndef CLOCK_SELECT_PARAMS_SVH
`define CLOCK_SELECT_PARAMS_SVH
`define CLOCK_MODE_SELECT_ADDR     8'h8f
`define CLOCK_MODE_SELECT_RESET    8'h00
`define DOUBLE_SPEED_BIT           0
`define TIMER_ZERO_SPEED_BIT       1
`define TIMER_ONE_SPEED_BIT        2
`define TIMER_TWO_SPEED_BIT        3
`define SERIAL_SPEED_BIT           4
`define COUNTER_ARRAY_SPEED_BIT    5
`define WATCHDOG_SPEED_BIT         6
`define CAN_SPEED_BIT              7
`define STANDARD_PERIODS           12
`define DOUBLE_PERIODS             6
`define PERIPHERAL_COUNT           7
`endif

// file: logic/clock_select_pkg.sv
// Types shared by the double speed clock selection block.
`default_nettype none
package clock_select_pkg;
  // Gray coded along standard to double speed.
  typedef enum logic [0:0] {
    standard_speed_mode = 1'b0,
    double_speed_mode   = 1'b1
  } speed_mode_type;
endpackage
`default_nettype wire

// file: logic/cycle_phase_counter.sv
// Counts oscillator periods and marks each machine or peripheral cycle.
`default_nettype none
module cycle_phase_counter #(
  parameter int WIDTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] periods,
  output logic                  cycle_strobe
);
  logic [WIDTH-1:0] count;
  wire              last = (count >= periods - WIDTH'(1));

  // A strobe marks the last oscillator period of every cycle.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count        <= '0;
      cycle_strobe <= 1'b0;
    end else begin
      cycle_strobe <= tick & last;
      if (tick) begin
        count <= last ? '0 : count + WIDTH'(1);
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/double_speed_clock_select.sv
// Double speed clock selection for the core and seven peripherals.
//
// Our own choice: the address-and-strobe port.
`default_nettype none
`include "clock_select_params.svh"
module double_speed_clock_select (
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  input  wire logic                         crystal_input,
  input  wire logic                         boot_double_speed_fuse,
  input  wire logic [7:0]                   addr,
  input  wire logic [7:0]                   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [7:0]                   rdata,
  output logic                              cpu_cycle,
  output logic      [`PERIPHERAL_COUNT-1:0] periph_cycle,
  output logic      [`PERIPHERAL_COUNT-1:0] periph_double,
  output logic                              cpu_double,
  output logic                              divided_clock
);
  // Crystal edges are sampled, so the crystal must be well below half of ref_clk.
  logic       xtal_meta;
  logic       xtal_sync;
  logic       xtal_prev;
  logic       fuse_meta;
  logic       fuse_sync;
  logic [1:0] fuse_age;
  logic       boot_pending;
  logic [7:0] clock_mode_select;
  clock_select_pkg::speed_mode_type mode;
  logic [`PERIPHERAL_COUNT-1:0] periph_active;

  // Returns the oscillator periods per cycle for a double speed request.
  function automatic logic [3:0] periods_for(input logic fast);
    periods_for = fast ? 4'(`DOUBLE_PERIODS) : 4'(`STANDARD_PERIODS);
  endfunction

  // Standard speed ticks come from the divided clock, so twelve periods are six ticks.
  function automatic logic [3:0] ticks_for(input logic unit_fast, input logic core_fast);
    ticks_for = core_fast ? periods_for(unit_fast) : 4'(`STANDARD_PERIODS / 2);
  endfunction

  wire crystal_rise  = xtal_sync & ~xtal_prev;
  wire select_hit    = (addr == `CLOCK_MODE_SELECT_ADDR);
  wire write_hit     = wr & select_hit;
  wire read_hit      = rd & select_hit;
  wire requested_x2  = clock_mode_select[`DOUBLE_SPEED_BIT];
  wire divided_rise  = crystal_rise & ~divided_clock;
  wire mode_fast     = (mode == clock_select_pkg::double_speed_mode);
  // Bypass takes every crystal edge, standard speed only every other one.
  wire osc_tick      = mode_fast ? crystal_rise : divided_rise;
  wire [`PERIPHERAL_COUNT-1:0] periph_bits = clock_mode_select[7:1];
  // A peripheral doubles only while the core is fast and its own bit is clear.
  wire [`PERIPHERAL_COUNT-1:0] next_periph_fast =
    {`PERIPHERAL_COUNT{mode_fast}} & ~periph_bits;
  wire [3:0] cpu_periods = ticks_for(mode_fast, mode_fast);

  // Two flip-flops bring the crystal and the fuse into the ref_clk domain.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
      fuse_meta <= 1'b0;
      fuse_sync <= 1'b0;
      fuse_age  <= 2'h0;
    end else begin
      xtal_meta <= crystal_input;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
      fuse_meta <= boot_double_speed_fuse;
      fuse_sync <= fuse_meta;
      fuse_age  <= {fuse_age[0], 1'b1}; // Marks when fuse_sync holds the pin level.
    end
  end

  // The divide by two stage toggles on each crystal rising edge.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      divided_clock <= 1'b0;
    end else if (crystal_rise) begin
      divided_clock <= ~divided_clock;
    end
  end

  // Software writes the register; the fuse is caught once after release.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clock_mode_select <= `CLOCK_MODE_SELECT_RESET;
      boot_pending      <= 1'b1;
    end else if (write_hit) begin
      clock_mode_select <= wdata;
      boot_pending      <= 1'b0;
    end else if (boot_pending && fuse_age[1]) begin
      clock_mode_select[`DOUBLE_SPEED_BIT] <= fuse_sync;
      boot_pending      <= 1'b0;
    end
  end

  // The mode follows the bit only on a divided clock rising edge, so no glitch.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode <= clock_select_pkg::standard_speed_mode;
    end else if (divided_rise) begin
      mode <= requested_x2 ? clock_select_pkg::double_speed_mode
                           : clock_select_pkg::standard_speed_mode;
    end
  end

  // Peripheral selections also change only on the divided rising edge.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      periph_active <= '0;
    end else if (divided_rise) begin
      periph_active <= next_periph_fast;
    end
  end

  // Outputs and read data come from flip-flops; read data lasts one cycle.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata         <= 8'h00;
      cpu_double    <= 1'b0;
      periph_double <= '0;
    end else begin
      rdata         <= read_hit ? clock_mode_select : 8'h00;
      cpu_double    <= mode_fast;
      periph_double <= periph_active;
    end
  end

  // One counter per clock user; a doubled peripheral gets a halved time base.
  cycle_phase_counter #(.WIDTH(4)) cpu_counter (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .tick         (osc_tick),
    .periods      (cpu_periods),
    .cycle_strobe (cpu_cycle)
  );

  genvar g;
  generate
    for (g = 0; g < `PERIPHERAL_COUNT; g++) begin : periph_gen
      cycle_phase_counter #(.WIDTH(4)) periph_counter (
        .ref_clk      (ref_clk),
        .nrst         (nrst),
        .tick         (osc_tick),
        .periods      (ticks_for(periph_active[g], mode_fast)),
        .cycle_strobe (periph_cycle[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire
